//--- bench/sep_command_port_sva.sv
`timescale 1ns/100ps
`include "sep_params.svh"
module sep_command_port_sva
#(
   parameter int unsigned TIMEOUT_CYCLES = 200
)
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [11:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        prom_cs,
   input wire logic        prom_sclk,
   input wire logic        prom_serial_data_out
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [21:0] cs_run_reg;
   logic [4:0]  rise_reg;
   logic        sclk_reg;
   wire         ar_go = s_axi_arvalid && s_axi_arready;
   ////////////////////////////////////////////////////////////////
   always_ff @(posedge aclk)
      sclk_reg <= aresetn && prom_sclk;
   // a hung ready wait shows as one long chip-select run
   always_ff @(posedge aclk)
      cs_run_reg <= (!aresetn || !prom_cs) ? 22'h0 : cs_run_reg + 22'h1;
   always_ff @(posedge aclk)
      rise_reg <= (!aresetn || !prom_cs) ? 5'h0 : rise_reg + 5'(prom_sclk && !sclk_reg);
   ////////////////////////////////////////////////////////////////
   sequence sclk_hi4;
      prom_sclk [*4];
   endsequence
   sequence sclk_lo4;
      !prom_sclk [*4];
   endsequence
   idle_clk_a: assert property (!prom_cs |-> !prom_sclk)
      else $error("serial clock moves without select");
   data_steady_a: assert property ($rose(prom_sclk) |-> $stable(prom_serial_data_out))
      else $error("data out changed at clock rise");
   high_half_a: assert property ($rose(prom_sclk) |-> sclk_hi4)
      else $error("serial clock high phase wrong");
   low_half_a: assert property ($fell(prom_sclk) |-> sclk_lo4)
      else $error("serial clock low phase wrong");
   frame_len_a: assert property ($fell(prom_cs) |-> rise_reg inside {5'd0, 5'd12, 5'd20, 5'd21})
      else $error("frame bit count wrong");
   cs_bound_a: assert property (cs_run_reg < TIMEOUT_CYCLES + 16)
      else $error("select held past the time-out");
   unmapped_read_a: assert property (ar_go && s_axi_araddr == 12'h038 |=>
      s_axi_rvalid && s_axi_rdata == 32'h0 && s_axi_rresp == `SEP_RESP_SLVERR)
      else $error("unmapped read not refused");
   data_upper_a: assert property (ar_go && s_axi_araddr == `SEP_ADDR_DATA |=>
      s_axi_rdata[31:8] == 24'h0)
      else $error("data register upper bits set");
   cmd_reserved_a: assert property (ar_go && s_axi_araddr == `SEP_ADDR_CMD |=>
      s_axi_rdata[27:11] == 17'h0)
      else $error("command register reserved bits set");
endmodule
bind sep_command_port sep_command_port_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_sva (.*);

//--- bench/sep_command_port_tb.sv
`timescale 1ns/100ps
`include "sep_params.svh"
module sep_command_port_tb;
   localparam int unsigned TO = 200;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, rd_last, d;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  mode;
   logic [8:0]  a;
   logic [7:0]  b;
   wire  logic  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   wire  logic  prom_cs, prom_sclk, prom_serial_data_out, prom_serial_data_in;
   wire  logic [1:0]  s_axi_bresp, s_axi_rresp;
   wire  logic [31:0] s_axi_rdata;
   logic [65:0] exp_q [$];
   logic [1:0]  exp_b [$];
   int          errors, checked;
   sep_command_port #(.TIMEOUT_CYCLES(TO)) u_dut (.*);
   sep_prom_model u_prom (.*);
   ////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk_rd(input logic [65:0] n);
      checked++;
      if ((s_axi_rdata & n[63:32]) !== (n[31:0] & n[63:32]) || s_axi_rresp !== n[65:64])
      begin
         errors++;
         $display("unexpected at %0t: read %h resp %b want %h", $time, s_axi_rdata, s_axi_rresp, n[31:0]);
      end
   endtask
   task automatic chk_wr(input logic [1:0] r);
      checked++;
      if (s_axi_bresp !== r)
      begin
         errors++;
         $display("unexpected at %0t: bresp %b", $time, s_axi_bresp);
      end
   endtask
   task automatic chk_irq(input logic e);
      repeat (3) @(posedge aclk);
      checked++;
      if (irq !== e)
      begin
         errors++;
         $display("unexpected at %0t: irq %b", $time, irq);
      end
   endtask
   task automatic wr(input logic [11:0] ad, input logic [31:0] dt);
      exp_b.push_back((ad == 12'h038) ? `SEP_RESP_SLVERR : `SEP_RESP_OKAY);
      s_axi_awaddr <= ad;
      s_axi_wdata <= dt;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      // one edge between transfers so ready is never reassigned in one step
      @(posedge aclk);
   endtask
   // mask 0 marks a poll whose value is not judged
   task automatic rd(input logic [11:0] ad, input logic [31:0] e, m, input logic [1:0] r);
      exp_q.push_back({r, m, e});
      s_axi_araddr <= ad;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      rd_last = s_axi_rdata;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic idle();
      rd_last = 32'hffffffff;
      while (rd_last[31] !== 1'b0)
         rd(`SEP_ADDR_CMD, 32'h0, 32'h0, 2'b00);
   endtask
   task automatic run(input logic [2:0] op);
      wr(`SEP_ADDR_CMD, {1'b1, op, 19'h0, a});
      idle();
   endtask
   ////////////////////////////////////////////////////////////////
   always @(posedge aclk)
      if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0)
         if (exp_q[0][63:32] == 32'h0)
            void'(exp_q.pop_front());
         else
            chk_rd(exp_q.pop_front());
   always @(posedge aclk)
      if (s_axi_bvalid && s_axi_bready && exp_b.size() > 0)
         chk_wr(exp_b.pop_front());
   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   initial
   begin
      #1000000;
      errors++;
      close_out();
   end
   initial
   begin
      void'($urandom(32'hcff2));
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn} = 6'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
      s_axi_wstrb = 4'hf;
      mode = 2'd0;
      foreach (u_prom.mem[i])
         u_prom.mem[i] = 8'($urandom);
      u_prom.mem[0] = 8'ha5;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      idle();
      rd(`SEP_ADDR_CMD, 32'h200, 32'h800007ff, 2'b00);
      rd(`SEP_ADDR_DATA, 32'h0, 32'hffffffff, 2'b00);
      d = $urandom;
      wr(`SEP_ADDR_DATA, d);
      rd(`SEP_ADDR_DATA, {24'h0, d[7:0]}, 32'hffffffff, 2'b00);
      $display("test power-up and data done");
      a = 9'($urandom);
      b = u_prom.mem[a];
      wr(`SEP_ADDR_CMD, {1'b1, 22'h0, a});
      wr(`SEP_ADDR_CMD, {1'b1, 3'b011, 19'h0, ~a});
      idle();
      rd(`SEP_ADDR_CMD, {23'h0, a}, 32'hf00005ff, 2'b00);
      rd(`SEP_ADDR_DATA, {24'h0, b}, 32'hffffffff, 2'b00);
      $display("test read done");
      wr(`SEP_ADDR_CMD, 32'h200);
      rd(`SEP_ADDR_CMD, 32'h0, 32'h200, 2'b00);
      run(3'b111);
      rd(`SEP_ADDR_CMD, 32'h200, 32'h200, 2'b00);
      u_prom.mem[0] = 8'h5a;
      wr(`SEP_ADDR_CMD, 32'h200);
      run(3'b111);
      rd(`SEP_ADDR_CMD, 32'h0, 32'h200, 2'b00);
      rd(`SEP_ADDR_DATA, {24'h0, b}, 32'hffffffff, 2'b00);
      run(3'b011);
      rd(`SEP_ADDR_CMD, 32'h0, 32'h400, 2'b00);
      $display("test reload done");
      wr(`SEP_ADDR_IRQ_EN, 32'h0);
      mode <= 2'd2;
      for (int op = 0; op < 8; op++)
      begin
         run(3'(op));
         rd(`SEP_ADDR_CMD, (op > 2 && op < 7) ? 32'h400 : 32'h0, 32'h80000400, 2'b00);
      end
      chk_irq(1'b0);
      wr(`SEP_ADDR_IRQ_EN, 32'h2);
      chk_irq(1'b1);
      wr(`SEP_ADDR_IRQ_CLR, 32'h7);
      chk_irq(1'b0);
      $display("test held-low and irq done");
      mode <= 2'd1;
      for (int op = 0; op < 8; op++)
      begin
         run(3'(op));
         rd(`SEP_ADDR_CMD, 32'h0, 32'h80000400, 2'b00);
      end
      wr(12'h038, 32'h0);
      rd(12'h038, 32'h0, 32'hffffffff, 2'b10);
      $display("test pulled-high and unmapped done");
      close_out();
   end
endmodule

//--- bench/sep_prom_model.sv
`timescale 1ns/100ps
module sep_prom_model
(
   input  wire logic       prom_cs,
   input  wire logic       prom_sclk,
   input  wire logic       prom_serial_data_out,
   input  wire logic [1:0] mode,
   output logic            prom_serial_data_in
);
   logic [7:0]  mem [512];
   logic [11:0] sh_reg;
   logic [8:0]  loc_reg;
   logic        rd_reg, rdy_reg, bit_reg;
   int          cnt;
   // slow ready: 100 system cycles, still inside the time-out
   always @(posedge prom_cs)
   begin
      cnt = 0;
      rd_reg = 1'b0;
      rdy_reg = 1'b0;
      rdy_reg <= #2000 1'b1;
   end
   always @(posedge prom_sclk)
      if (prom_cs)
      begin
         sh_reg = {sh_reg[10:0], prom_serial_data_out};
         cnt++;
      end
   always @(negedge prom_sclk)
      if (cnt == 12)
      begin
         rd_reg = (sh_reg[10:9] == 2'b10);
         loc_reg = sh_reg[8:0];
         bit_reg = 1'b0;
      end
      else if (cnt > 12 && cnt < 21)
         bit_reg = mem[loc_reg][20-cnt];
   // mode 1: absent, pulled high; mode 2: absent, held low
   assign prom_serial_data_in = (mode == 2'd1) ? 1'b1 : (mode == 2'd2) ? 1'b0 :
                                !prom_cs ? 1'b1 : rd_reg ? bit_reg : rdy_reg;
endmodule

//--- rtl/sep_command_port.sv
`timescale 1ns/100ps
`include "sep_params.svh"
module sep_command_port
   import sep_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = `SEP_TIMEOUT_CYCLES
)
(
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic [`SEP_AXI_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [`SEP_AXI_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   input  wire logic                       prom_serial_data_in,
   output logic                            prom_cs,
   output logic                            prom_sclk,
   output logic                            prom_serial_data_out,
   output logic                            irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // declarations

   logic                       aw_held_reg;
   logic [`SEP_AXI_ADDR_W-1:0] awaddr_reg;
   logic                       w_held_reg;
   logic [31:0]                wdata_reg;
   logic [31:0]                wmask_reg;
   logic                       wr_fire;
   logic                       wr_mapped;

   logic                       busy_reg;
   sep_cmd_type                op_reg;
   logic [8:0]                 addr_reg;
   logic [7:0]                 data_reg;
   logic                       timeout_reg;
   logic                       loaded_reg;
   logic [`SEP_IRQ_W-1:0]      irq_stat_reg;
   logic [`SEP_IRQ_W-1:0]      irq_en_reg;
   logic [`SEP_IRQ_W-1:0]      events;

   sep_state_type              state_reg;
   logic [`SEP_FRAME_W-1:0]    tx_sr_reg;
   logic [7:0]                 rx_sr_reg;
   logic [4:0]                 bit_cnt_reg;
   logic [31:0]                wait_cnt_reg;
   logic                       timed_out_reg;
   logic                       din_sync;
   logic                       tick;
   logic                       eng_end;
   logic                       load_ok;
   logic                       write_type;
   logic [31:0]                cmd_word;

   ////////////////////////////////////////////////////////////////////////////////
   // frame build

   function automatic logic [`SEP_FRAME_W-1:0] build_frame(input sep_cmd_type op,
                                                           input logic [8:0] a,
                                                           input logic [7:0] d);
      logic [`SEP_FRAME_W-1:0] f;
      f = '0;
      case (op)
         sep_read_cmd:                f = {1'b1, `SEP_OPC_READ, a, 9'h000};
         sep_reload_cmd:              f = {1'b1, `SEP_OPC_READ, `SEP_RESET_ADDR, 9'h000};
         sep_write_cmd:               f = {1'b1, `SEP_OPC_WRITE, a, d, 1'b0};
         sep_erase_cmd:               f = {1'b1, `SEP_OPC_ERASE, a, 9'h000};
         sep_erase_write_enable_cmd:  f = {1'b1, `SEP_OPC_EXT, `SEP_EXT_ENABLE, 7'h00, 9'h000};
         sep_erase_write_disable_cmd: f = {1'b1, `SEP_OPC_EXT, `SEP_EXT_DISABLE, 7'h00, 9'h000};
         sep_write_all_cmd:           f = {1'b1, `SEP_OPC_EXT, `SEP_EXT_WRITE_ALL, 7'h00, d, 1'b0};
         sep_erase_all_cmd:           f = {1'b1, `SEP_OPC_EXT, `SEP_EXT_ERASE_ALL, 7'h00, 9'h000};
         default:                     f = '0;
      endcase
      return f;
   endfunction

   function automatic logic [4:0] frame_bits(input sep_cmd_type op);
      logic [4:0] n;
      n = `SEP_BITS_SHORT;
      case (op)
         sep_read_cmd, sep_reload_cmd:     n = `SEP_BITS_READ;
         sep_write_cmd, sep_write_all_cmd: n = `SEP_BITS_WRITE;
         default:                          n = `SEP_BITS_SHORT;
      endcase
      return n;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   sep_sync #(.WIDTH(1)) u_din_sync
   (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (prom_serial_data_in),
      .sync_out (din_sync)
   );

   sep_tick_div u_tick_div
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (state_reg != sep_idle),
      .tick    (tick)
   );

   // only erasing and writing commands poll for ready, so only they can time out
   assign write_type = (op_reg == sep_write_cmd) || (op_reg == sep_write_all_cmd) ||
                       (op_reg == sep_erase_cmd) || (op_reg == sep_erase_all_cmd);
   assign eng_end    = (state_reg == sep_finish);
   assign load_ok    = eng_end && (op_reg == sep_reload_cmd) && !timed_out_reg &&
                       (rx_sr_reg == `SEP_SIGNATURE);
   assign events     = {load_ok, eng_end && timed_out_reg, eng_end};

   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite write channels

   assign wr_fire   = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wr_mapped = (awaddr_reg == `SEP_ADDR_CMD) || (awaddr_reg == `SEP_ADDR_DATA) ||
                      (awaddr_reg == `SEP_ADDR_IRQ_CLR) || (awaddr_reg == `SEP_ADDR_IRQ_EN) ||
                      (awaddr_reg == `SEP_ADDR_IRQ_STAT);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg   <= 1'b0;
         awaddr_reg    <= '0;
         s_axi_awready <= 1'b0;
         w_held_reg    <= 1'b0;
         wdata_reg     <= 32'h00000000;
         wmask_reg     <= 32'h00000000;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `SEP_RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wmask_reg  <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
         end
         if (wr_fire)
         begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= wr_mapped ? `SEP_RESP_OKAY : `SEP_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // command and data registers

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         busy_reg    <= 1'b1; // power-up load runs straight out of reset
         op_reg      <= sep_reload_cmd;
         addr_reg    <= `SEP_RESET_ADDR;
         data_reg    <= `SEP_RESET_DATA;
         timeout_reg <= 1'b0;
         loaded_reg  <= 1'b0;
      end
      else
      begin
         if (wr_fire && (awaddr_reg == `SEP_ADDR_CMD) && !busy_reg)
         begin
            // command and address only change while idle
            if (wmask_reg[`SEP_CMD_OP_HI])
               op_reg <= sep_cmd_type'(wdata_reg[`SEP_CMD_OP_HI:`SEP_CMD_OP_LO]);
            addr_reg <= (addr_reg & ~wmask_reg[`SEP_CMD_ADDR_HI:0]) |
                        (wdata_reg[`SEP_CMD_ADDR_HI:0] & wmask_reg[`SEP_CMD_ADDR_HI:0]);
            if (wmask_reg[`SEP_CMD_BUSY_BIT] && wdata_reg[`SEP_CMD_BUSY_BIT])
            begin
               busy_reg    <= 1'b1;
               timeout_reg <= 1'b0;
            end
         end
         if (wr_fire && (awaddr_reg == `SEP_ADDR_DATA) && !busy_reg)
            data_reg <= (data_reg & ~wmask_reg[`SEP_DATA_HI:0]) |
                        (wdata_reg[`SEP_DATA_HI:0] & wmask_reg[`SEP_DATA_HI:0]);
         // clear by writing one; a load finishing in the same cycle wins
         if (wr_fire && (awaddr_reg == `SEP_ADDR_CMD) && wmask_reg[`SEP_CMD_LOADED_BIT] &&
             wdata_reg[`SEP_CMD_LOADED_BIT])
            loaded_reg <= 1'b0;
         if (load_ok)
            loaded_reg <= 1'b1;
         if (eng_end)
         begin
            busy_reg <= 1'b0;
            if (timed_out_reg)
               timeout_reg <= 1'b1;
            if (op_reg == sep_read_cmd)
               data_reg <= rx_sr_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // serial engine

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg            <= sep_idle;
         tx_sr_reg            <= '0;
         rx_sr_reg            <= 8'h00;
         bit_cnt_reg          <= 5'h00;
         wait_cnt_reg         <= 32'h00000000;
         timed_out_reg        <= 1'b0;
         prom_cs              <= 1'b0;
         prom_sclk            <= 1'b0;
         prom_serial_data_out <= 1'b0;
      end
      else
      begin
         case (state_reg)
            sep_idle:
            begin
               timed_out_reg <= 1'b0;
               if (busy_reg)
                  state_reg <= sep_frame_load;
            end
            sep_frame_load:
            begin
               if (tick)
               begin
                  tx_sr_reg            <= build_frame(op_reg, addr_reg, data_reg);
                  prom_serial_data_out <= 1'b1;
                  bit_cnt_reg          <= frame_bits(op_reg);
                  prom_cs              <= 1'b1;
                  state_reg            <= sep_shift;
               end
            end
            sep_shift:
            begin
               if (tick && !prom_sclk)
               begin
                  prom_sclk <= 1'b1;
                  rx_sr_reg <= {rx_sr_reg[6:0], din_sync};
               end
               else if (tick)
               begin
                  prom_sclk <= 1'b0;
                  if (bit_cnt_reg == 5'h01)
                  begin
                     prom_cs              <= 1'b0;
                     prom_serial_data_out <= 1'b0;
                     state_reg            <= sep_cs_gap;
                  end
                  else
                  begin
                     bit_cnt_reg          <= bit_cnt_reg - 5'h01;
                     tx_sr_reg            <= {tx_sr_reg[`SEP_FRAME_W-2:0], 1'b0};
                     prom_serial_data_out <= tx_sr_reg[`SEP_FRAME_W-2];
                  end
               end
            end
            sep_cs_gap:
            begin
               if (tick && write_type)
               begin
                  prom_cs      <= 1'b1;
                  wait_cnt_reg <= 32'h00000000;
                  state_reg    <= sep_wait_ready;
               end
               else if (tick)
                  state_reg <= sep_finish;
            end
            sep_wait_ready:
            begin
               // ready shows as a high input; a floating-high input ends at once
               wait_cnt_reg <= wait_cnt_reg + 32'h00000001;
               if (tick && din_sync)
               begin
                  prom_cs   <= 1'b0;
                  state_reg <= sep_finish;
               end
               else if (wait_cnt_reg >= 32'(TIMEOUT_CYCLES - 1))
               begin
                  prom_cs       <= 1'b0;
                  timed_out_reg <= 1'b1;
                  state_reg     <= sep_finish;
               end
            end
            sep_finish:
            begin
               state_reg <= sep_idle;
            end
            default:
            begin
               state_reg <= sep_idle;
               prom_cs   <= 1'b0;
               prom_sclk <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupts

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_stat_reg <= '0;
         irq_en_reg   <= '0;
         irq          <= 1'b0;
      end
      else
      begin
         // set wins over a clear in the same cycle
         if (wr_fire && (awaddr_reg == `SEP_ADDR_IRQ_CLR) && wmask_reg[0])
            irq_stat_reg <= (irq_stat_reg & ~wdata_reg[`SEP_IRQ_W-1:0]) | events;
         else
            irq_stat_reg <= irq_stat_reg | events;
         if (wr_fire && (awaddr_reg == `SEP_ADDR_IRQ_EN) && wmask_reg[0])
            irq_en_reg <= wdata_reg[`SEP_IRQ_W-1:0];
         irq <= |(irq_stat_reg & irq_en_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite read channels

   always_comb
   begin
      cmd_word                                       = 32'h00000000;
      cmd_word[`SEP_CMD_BUSY_BIT]                    = busy_reg;
      cmd_word[`SEP_CMD_OP_HI:`SEP_CMD_OP_LO]        = op_reg;
      cmd_word[`SEP_CMD_TIMEOUT_BIT]                 = timeout_reg;
      cmd_word[`SEP_CMD_LOADED_BIT]                  = loaded_reg;
      cmd_word[`SEP_CMD_ADDR_HI:0]                   = addr_reg;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `SEP_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `SEP_RESP_OKAY;
            case (s_axi_araddr)
               `SEP_ADDR_CMD:      s_axi_rdata <= cmd_word;
               `SEP_ADDR_DATA:     s_axi_rdata <= {24'h000000, data_reg};
               `SEP_ADDR_IRQ_STAT: s_axi_rdata <= {29'h00000000, irq_stat_reg};
               `SEP_ADDR_IRQ_CLR:  s_axi_rdata <= 32'h00000000;
               `SEP_ADDR_IRQ_EN:   s_axi_rdata <= {29'h00000000, irq_en_reg};
               default:
               begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `SEP_RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule

//--- rtl/sep_params.svh
`ifndef SEP_PARAMS_SVH
`define SEP_PARAMS_SVH

`define SEP_AXI_ADDR_W      12
`define SEP_ADDR_CMD        12'h030
`define SEP_ADDR_DATA       12'h034
`define SEP_ADDR_IRQ_STAT   12'h040
`define SEP_ADDR_IRQ_CLR    12'h044
`define SEP_ADDR_IRQ_EN     12'h048

`define SEP_CMD_BUSY_BIT    31
`define SEP_CMD_OP_HI       30
`define SEP_CMD_OP_LO       28
`define SEP_CMD_TIMEOUT_BIT 10
`define SEP_CMD_LOADED_BIT  9
`define SEP_CMD_ADDR_HI     8
`define SEP_DATA_HI         7

`define SEP_RESET_ADDR      9'h000
`define SEP_RESET_DATA      8'h00
`define SEP_SIGNATURE       8'ha5

`define SEP_IRQ_W           3
`define SEP_IRQ_DONE        0
`define SEP_IRQ_TIMEOUT     1
`define SEP_IRQ_LOADED      2

`define SEP_RESP_OKAY       2'b00
`define SEP_RESP_SLVERR     2'b10

`define SEP_TIMEOUT_MS      30
`define SEP_CLK_HZ          50000000
`define SEP_TIMEOUT_CYCLES  (`SEP_TIMEOUT_MS * (`SEP_CLK_HZ / 1000))
`define SEP_SCLK_HALF       4

`define SEP_FRAME_W         21
`define SEP_BITS_SHORT      5'd12
`define SEP_BITS_WRITE      5'd20
`define SEP_BITS_READ       5'd21
`define SEP_OPC_READ        2'b10
`define SEP_OPC_WRITE       2'b01
`define SEP_OPC_ERASE       2'b11
`define SEP_OPC_EXT         2'b00
`define SEP_EXT_ENABLE      2'b11
`define SEP_EXT_DISABLE     2'b00
`define SEP_EXT_WRITE_ALL   2'b01
`define SEP_EXT_ERASE_ALL   2'b10

`endif

//--- rtl/sep_pkg.sv
package sep_pkg;

   typedef enum logic [2:0]
   {
      sep_read_cmd                = 3'b000,
      sep_erase_write_disable_cmd = 3'b001,
      sep_erase_write_enable_cmd  = 3'b010,
      sep_write_cmd               = 3'b011,
      sep_write_all_cmd           = 3'b100,
      sep_erase_cmd               = 3'b101,
      sep_erase_all_cmd           = 3'b110,
      sep_reload_cmd              = 3'b111
   } sep_cmd_type;

   typedef enum logic [2:0]
   {
      sep_idle       = 3'b000,
      sep_frame_load = 3'b001,
      sep_shift      = 3'b010,
      sep_cs_gap     = 3'b011,
      sep_wait_ready = 3'b100,
      sep_finish     = 3'b101
   } sep_state_type;

endpackage

//--- rtl/sep_sync.sv
`timescale 1ns/100ps
module sep_sync
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   // first stage feeds only the second stage
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               meta_reg[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end
            else
            begin
               meta_reg[i] <= async_in[i];
               sync_out[i] <= meta_reg[i];
            end
         end
      end
   endgenerate

endmodule

//--- rtl/sep_tick_div.sv
`timescale 1ns/100ps
`include "sep_params.svh"
module sep_tick_div
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic run,
   output logic      tick
);

   logic [3:0] cnt_reg;

   // held at zero while idle so each frame starts on a full half period
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !run)
      begin
         cnt_reg <= 4'h0;
         tick    <= 1'b0;
      end
      else if (cnt_reg == 4'(`SEP_SCLK_HALF - 1))
      begin
         cnt_reg <= 4'h0;
         tick    <= 1'b1;
      end
      else
      begin
         cnt_reg <= cnt_reg + 4'h1;
         tick    <= 1'b0;
      end
   end

endmodule
